// >>> verilog/socket_defs.svh
/*
  Offsets, field positions and reset values of the socket status and mask registers.
  Assumes inclusion by bare name from any design file that needs them.
*/
`ifndef SOCKET_DEFS_SVH
`define SOCKET_DEFS_SVH

`define SOCK_ADDR_W 8
`define SOCK_OFF_EVENT 8'h00
`define SOCK_OFF_MASK 8'h04
`define SOCK_OFF_STATE 8'h08
`define SOCK_OFF_FORCE 8'h0c

`define SOCK_N_EVENTS 4
`define EV_CARD_STATUS 0
`define EV_CD1 1
`define EV_CD2 2
`define EV_POWER 3

`define MASK_CSTS_BIT 0
`define MASK_CD_LO 1
`define MASK_CD_HI 2
`define MASK_PWR_BIT 3
`define MASK_RESET 4'h0
`define MASK_CD_ENABLE 2'h3

`define ST_YY_SOCKET 31
`define ST_XX_SOCKET 30
`define ST_3V3_SOCKET 29
`define ST_5V_SOCKET 28
`define ST_CARD_VS_HI 13
`define ST_CARD_VS_LO 10
`define ST_BAD_VCC 9
`define ST_DATA_LOSS 8
`define ST_POWERED 3
`define ST_CD2 2
`define ST_CD1 1
`define ST_CARD_STATUS 0

`define SOCK_CAP_RESET 3'h1
`define CARD_VS_RESET 4'h0
`define CD_PIN_RESET 1'h1
`define ZERO_WORD 32'h0000_0000

`endif

// >>> verilog/socket_pkg.sv
/*
  Types shared by the socket register bank: register request and socket status inputs.
  Assumes socket_defs.svh for the widths.
*/
`include "socket_defs.svh"

package socket_pkg;

  typedef struct packed {
    logic [`SOCK_ADDR_W-1:0] addr;
    logic wr;
    logic rd;
    logic [31:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic card_detect_pin_1;
    logic card_detect_pin_2;
    logic card_status_pin;
    logic cardbus_card;
    logic socket_power_on;
    logic card_ident_busy;
    logic card_insert_done;
    logic [3:0] card_vs_caps;
    logic bad_vcc_detect;
    logic removal_loss_detect;
  } socket_in_s;

endpackage

// >>> verilog/event_flag_bank.sv
/*
  Bank of sticky event flags, one per socket event, set by hardware and cleared by write-1.
  Assumes set and clear arrive as one-cycle pulses synchronous to clk.
*/
`timescale 1ns/1ps

module event_flag_bank #(
  parameter int N = 4
) (
  input wire logic clk,
  input wire logic sticky_clr,
  input wire logic [N-1:0] set_pulse,
  input wire logic [N-1:0] clr_pulse,
  output logic [N-1:0] flags
);

  logic [N-1:0] flag_reg;
  logic [N-1:0] flag_next;

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_flag
      always_comb begin
        // set beats a clear landing in the same cycle
        if (set_pulse[i]) begin
          flag_next[i] = 1'b1;
        end else if (clr_pulse[i]) begin
          flag_next[i] = 1'b0;
        end else begin
          flag_next[i] = flag_reg[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (sticky_clr) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flags = flag_reg;

endmodule

// >>> verilog/cardbus_socket_status_mask.sv
/*
  Socket event, mask, present state and force event registers of a card socket, with the
  status change interrupt built from event flags and their masks.
  Assumes one register request at a time on a simple strobe port; socket inputs synchronous.
*/
// Behaviour
// - event flags update on every event whatever the mask holds
// - mask register bits 31 to 4 read as zero
// - mask bit 3 lets power-cycle events raise the interrupt; default off
// - card-detect mask code 11 enables, 00 blocks; 01 and 10 reserved
// - mask bit 0 lets card-status events raise the interrupt; default off
// - sticky bits cleared by global reset, or bus reset when events disabled
// - present state shows force-event writes and live socket status
// - card voltage bits change at card insertion and on force-event writes
// - card-detect changes hidden while card identification runs
// - Y.Y and X.X socket bits read zero unless forced
// - 3.3 volt socket bit reads one unless forced
// - 5 volt socket bit reads one unless device control bit 6 overrides
// - present state bits 27 to 14 read zero
// - card voltage bits report card, force-event one sets each
// - invalid voltage request sets bit 9, zero normally
// - possible data loss at removal sets bit 8, zero normally
// - interrupt asserted while any flag is set and enabled by its mask
// - flag set on change of its present-state field; card status of a cardbus card on rising edges only
`timescale 1ns/1ps
`include "socket_defs.svh"

module cardbus_socket_status_mask (
  input wire logic clk,
  input wire logic rst,
  input wire logic bus_reset_pin,
  input wire logic pme_enable,
  input wire logic ctrl_5v_override,
  input wire socket_pkg::reg_req_s req,
  input wire socket_pkg::socket_in_s sock,
  output logic [31:0] reg_rdata,
  output logic reg_ack,
  output logic status_change_interrupt
);
  import socket_pkg::*;

  logic sticky_clr;
  logic [3:0] mask_reg;
  logic [3:0] mask_next;
  logic [2:0] sock_cap_reg;
  logic [2:0] sock_cap_next;
  logic [3:0] card_vs_reg;
  logic [3:0] card_vs_next;
  logic bad_vcc_reg;
  logic bad_vcc_next;
  logic data_loss_reg;
  logic data_loss_next;
  logic powered_reg;
  logic powered_next;
  logic cd1_reg;
  logic cd1_next;
  logic cd2_reg;
  logic cd2_next;
  logic csts_reg;
  logic csts_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic ack_reg;
  logic ack_next;
  logic [`SOCK_N_EVENTS-1:0] ev_set;
  logic [`SOCK_N_EVENTS-1:0] ev_clr;
  logic [`SOCK_N_EVENTS-1:0] ev_flags;
  logic [`SOCK_N_EVENTS-1:0] ev_enable;
  logic [31:0] state_word;
  logic wr_mask;
  logic wr_event;
  logic wr_force;
  logic csts_rise;
  logic csts_fall;

  // sticky context survives bus reset while power management events are on
  assign sticky_clr = rst | (bus_reset_pin & ~pme_enable);

  // write decode; the present state offset and unmapped offsets select nothing
  always_comb begin
    wr_mask = 1'b0;
    wr_event = 1'b0;
    wr_force = 1'b0;
    if (req.wr) begin
      case (req.addr)
        `SOCK_OFF_EVENT: begin
          wr_event = 1'b1;
        end
        `SOCK_OFF_MASK: begin
          wr_mask = 1'b1;
        end
        `SOCK_OFF_FORCE: begin
          wr_force = 1'b1;
        end
        default: begin
          wr_mask = 1'b0;
        end
      endcase
    end
  end

  // mask register: only the low four bits are stored
  always_comb begin
    mask_next = mask_reg;
    if (wr_mask) begin
      mask_next = req.wdata[`MASK_PWR_BIT:`MASK_CSTS_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (sticky_clr) begin
      mask_reg <= `MASK_RESET;
    end else begin
      mask_reg <= mask_next;
    end
  end

  // socket capability bits are not sticky context, so only global reset reloads them to 3'h1
  always_comb begin
    sock_cap_next = sock_cap_reg;
    if (wr_force) begin
      sock_cap_next = req.wdata[`ST_YY_SOCKET:`ST_3V3_SOCKET];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sock_cap_reg <= `SOCK_CAP_RESET;
    end else begin
      sock_cap_reg <= sock_cap_next;
    end
  end

  // card voltage support, invalid voltage and data loss status
  always_comb begin
    card_vs_next = card_vs_reg;
    bad_vcc_next = bad_vcc_reg;
    data_loss_next = data_loss_reg;
    if (sock.card_insert_done) begin
      card_vs_next = sock.card_vs_caps;
    end
    if (wr_force) begin
      card_vs_next = card_vs_next | req.wdata[`ST_CARD_VS_HI:`ST_CARD_VS_LO];
      bad_vcc_next = req.wdata[`ST_BAD_VCC];
      data_loss_next = req.wdata[`ST_DATA_LOSS];
    end
    if (sock.bad_vcc_detect) begin
      bad_vcc_next = 1'b1;
    end
    if (sock.removal_loss_detect) begin
      data_loss_next = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sticky_clr) begin
      card_vs_reg <= `CARD_VS_RESET;
      bad_vcc_reg <= 1'b0;
      data_loss_reg <= 1'b0;
    end else begin
      card_vs_reg <= card_vs_next;
      bad_vcc_reg <= bad_vcc_next;
      data_loss_reg <= data_loss_next;
    end
  end

  // live socket levels; card detect frozen while identification drives the pins
  always_comb begin
    powered_next = sock.socket_power_on;
    csts_next = sock.card_status_pin;
    cd1_next = cd1_reg;
    cd2_next = cd2_reg;
    if (!sock.card_ident_busy) begin
      cd1_next = sock.card_detect_pin_1;
      cd2_next = sock.card_detect_pin_2;
    end
  end

  always_ff @(posedge clk) begin
    if (sticky_clr) begin
      powered_reg <= 1'b0;
      cd1_reg <= `CD_PIN_RESET;
      cd2_reg <= `CD_PIN_RESET;
      csts_reg <= 1'b0;
    end else begin
      powered_reg <= powered_next;
      cd1_reg <= cd1_next;
      cd2_reg <= cd2_next;
      csts_reg <= csts_next;
    end
  end

  // event detection on present-state field changes
  // card status edges, both directions kept apart for the card type choice
  always_comb begin
    csts_rise = 1'b0;
    csts_fall = 1'b0;
    if (csts_next && !csts_reg) begin
      csts_rise = 1'b1;
    end
    if (!csts_next && csts_reg) begin
      csts_fall = 1'b1;
    end
  end

  always_comb begin
    ev_set = '0;
    ev_set[`EV_POWER] = powered_next ^ powered_reg;
    ev_set[`EV_CD1] = cd1_next ^ cd1_reg;
    ev_set[`EV_CD2] = cd2_next ^ cd2_reg;
    // cardbus cards flag rising edges only, 16-bit cards both edges
    ev_set[`EV_CARD_STATUS] = csts_rise | (csts_fall & ~sock.cardbus_card);
    if (sticky_clr) begin
      ev_set = '0;
    end else if (wr_force) begin
      ev_set = ev_set | req.wdata[`SOCK_N_EVENTS-1:0];
    end
  end

  // write one clears a flag; a set landing in the same cycle still wins
  always_comb begin
    ev_clr = '0;
    if (wr_event) begin
      ev_clr = req.wdata[`SOCK_N_EVENTS-1:0];
    end
  end

  // flags never look at the mask
  event_flag_bank #(
    .N(`SOCK_N_EVENTS)
  ) u_flags (
    .clk(clk),
    .sticky_clr(sticky_clr),
    .set_pulse(ev_set),
    .clr_pulse(ev_clr),
    .flags(ev_flags)
  );

  // reserved card-detect codes 01 and 10 block the interrupt
  always_comb begin
    ev_enable = '0;
    ev_enable[`EV_POWER] = mask_reg[`MASK_PWR_BIT];
    ev_enable[`EV_CARD_STATUS] = mask_reg[`MASK_CSTS_BIT];
    ev_enable[`EV_CD1] = (mask_reg[`MASK_CD_HI:`MASK_CD_LO] == `MASK_CD_ENABLE);
    ev_enable[`EV_CD2] = (mask_reg[`MASK_CD_HI:`MASK_CD_LO] == `MASK_CD_ENABLE);
  end

  assign status_change_interrupt = |(ev_flags & ev_enable);

  // present state word
  always_comb begin
    state_word = `ZERO_WORD;
    state_word[`ST_YY_SOCKET:`ST_3V3_SOCKET] = sock_cap_reg;
    state_word[`ST_5V_SOCKET] = ~ctrl_5v_override;
    state_word[`ST_CARD_VS_HI:`ST_CARD_VS_LO] = card_vs_reg;
    state_word[`ST_BAD_VCC] = bad_vcc_reg;
    state_word[`ST_DATA_LOSS] = data_loss_reg;
    state_word[`ST_POWERED] = powered_reg;
    state_word[`ST_CD2] = cd2_reg;
    state_word[`ST_CD1] = cd1_reg;
    state_word[`ST_CARD_STATUS] = csts_reg;
  end

  // read port: data registered, ack one cycle after the strobe
  always_comb begin
    rdata_next = rdata_reg;
    ack_next = req.rd | req.wr;
    if (req.rd) begin
      case (req.addr)
        `SOCK_OFF_EVENT: begin
          rdata_next = {28'h0000000, ev_flags};
        end
        `SOCK_OFF_MASK: begin
          rdata_next = {28'h0000000, mask_reg};
        end
        `SOCK_OFF_STATE: begin
          rdata_next = state_word;
        end
        `SOCK_OFF_FORCE: begin
          rdata_next = `ZERO_WORD; // force register is write-only
        end
        default: begin
          rdata_next = `ZERO_WORD;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= `ZERO_WORD;
      ack_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      ack_reg <= ack_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_ack = ack_reg;

endmodule

// >>> verif/sock_mask_checker.sv
/* port assertions on the socket register bank; bound from the bench top file */
`timescale 1ns/1ps
module sock_mask_checker import socket_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic bus_reset_pin,
  input wire logic pme_enable,
  input wire logic ctrl_5v_override,
  input wire reg_req_s req,
  input wire socket_in_s sock,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic status_change_interrupt
);
  logic [3:0] msk_reg;
  logic frc_reg;
  logic rm;
  logic rs;
  logic bz;
  logic en;
  assign rm = req.rd && req.addr == 8'h04;
  assign rs = req.rd && req.addr == 8'h08;
  assign bz = sock.card_ident_busy;
  assign en = msk_reg[3] | msk_reg[0] | (&msk_reg[2:1]);
  // shadow of the mask and of any force write
  always_ff @(posedge clk) begin
    if (rst || (bus_reset_pin && !pme_enable))
      msk_reg <= 4'h0;
    else if (req.wr && req.addr == 8'h04)
      msk_reg <= req.wdata[3:0];
    frc_reg <= !rst && (frc_reg || (req.wr && req.addr == 8'h0c));
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_ack_timing: assert property (1 |=> reg_ack == $past(req.rd || req.wr))
    else $error("ack timing");
  a_mask_rb: assert property (rm |=> reg_rdata == {28'h0, $past(msk_reg)})
    else $error("mask readback");
  a_irq_masked: assert property (!en |-> !status_change_interrupt)
    else $error("irq while masked");
  a_bus_clear: assert property (bus_reset_pin && !pme_enable |=> !status_change_interrupt)
    else $error("irq after bus reset");
  a_sock_caps: assert property (rs && !frc_reg |=> reg_rdata[31:29] == 3'h1)
    else $error("socket caps");
  a_sock_5v: assert property (rs |=> reg_rdata[28] == !$past(ctrl_5v_override))
    else $error("5v bit");
  a_state_rsvd: assert property (rs |=> reg_rdata[27:14] == 14'h0)
    else $error("reserved state bits");
  a_cd_frozen: assert property (bz && rs ##1 bz ##1 bz && rs
    |=> reg_rdata[2:1] == $past(reg_rdata[2:1], 2))
    else $error("detect moved in ident");
endmodule

// >>> verif/pc_card_model.sv
/* card in the socket; the bench commands insertion and socket-side pulses */
`timescale 1ns/1ps
module pc_card_model import socket_pkg::*; (
  input wire logic clk,
  input wire logic insert,
  input wire logic cs_level,
  input wire logic cb_card,
  input wire logic power_on,
  input wire logic bad_vcc,
  input wire logic loss,
  input wire logic [3:0] caps,
  output socket_in_s sock
);
  logic in_reg = 1'b0;
  logic [3:0] cnt_reg = 4'h0;
  logic bz;
  assign bz = cnt_reg != 4'h0;
  always_ff @(posedge clk) begin
    in_reg <= insert;
    cnt_reg <= (insert && !in_reg) ? 4'h8 : cnt_reg - {3'h0, bz};
  end
  // empty socket pulls detect pins high; identification wiggles them
  assign sock = {!in_reg | (bz & cnt_reg[0]), !in_reg | (bz & cnt_reg[1]), cs_level, cb_card,
    power_on, bz, cnt_reg == 4'h1, caps, bad_vcc, loss};
endmodule

// >>> verif/cardbus_socket_status_mask_bench.sv
/* self-checking bench; needs the card model and checker compiled first */
`timescale 1ns/1ps
module cardbus_socket_status_mask_bench;
  import socket_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic brst = 1'b0;
  logic pme = 1'b0;
  logic ov = 1'b0;
  logic ins = 1'b0;
  logic cs = 1'b0;
  logic pwr = 1'b0;
  logic bv = 1'b0;
  logic ls = 1'b0;
  logic cbc = 1'b1;
  logic [3:0] caps = 4'h0;
  logic [3:0] m;
  logic [31:0] d;
  logic [31:0] rdata;
  logic ack;
  logic irq;
  reg_req_s req = '0;
  socket_in_s sock;
  int failures = 0;
  int cmp_count = 0;
  int seed = 82;
  int cyc = 0;
  always #5 clk = ~clk;
  cardbus_socket_status_mask DUT (.clk(clk), .rst(rst), .bus_reset_pin(brst), .pme_enable(pme),
    .ctrl_5v_override(ov), .req(req), .sock(sock), .reg_rdata(rdata), .reg_ack(ack),
    .status_change_interrupt(irq));
  pc_card_model card (.clk(clk), .insert(ins), .cs_level(cs), .cb_card(cbc), .power_on(pwr),
    .bad_vcc(bv), .loss(ls), .caps(caps), .sock(sock));
  function automatic logic [31:0] st(input logic o, input logic [3:0] c, input logic p,
    input logic [1:0] cd, input logic s);
    return {3'h1, !o, 14'h0, c, 2'h0, 4'h0, p, cd, s};
  endfunction
  function automatic logic irq_of(input logic [3:0] f, input logic [3:0] k);
    return |(f & {k[3], &k[2:1], &k[2:1], k[0]});
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    req <= '{addr: a, wr: w, rd: !w, wdata: v};
    @(posedge clk);
    req <= '0;
    #1;
    d = rdata;
    chk("ack", 32'h1, {31'h0, ack});
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(n, e, d);
  endtask
  task automatic msweep(input logic [3:0] f);
    for (int i = 0; i < 16; i++) begin
      acc(1'b1, 8'h04, $random(seed) << 4 | i);
      chk("irq", {31'h0, irq_of(f, 4'(i))}, {31'h0, irq});
      rdc("mask", 8'h04, 32'(i));
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rdc("mask", 8'h04, 32'h0);
    acc(1'b1, 8'h08, 32'hffff_ffff);
    rdc("state", 8'h08, st(1'b0, 4'h0, 1'b0, 2'h3, 1'b0));
    @(posedge clk);
    ov <= 1'b1;
    cs <= 1'b1;
    pwr <= 1'b1;
    rdc("live", 8'h08, st(1'b1, 4'h0, 1'b1, 2'h3, 1'b1));
    rdc("flags", 8'h00, 32'h9);
    msweep(4'h9);
    acc(1'b1, 8'h00, 32'hf);
    @(posedge clk);
    ov <= 1'b0;
    ins <= 1'b1;
    caps <= 4'($random(seed));
    rdc("ident", 8'h08, st(1'b0, 4'h0, 1'b1, 2'h3, 1'b1));
    rdc("ident", 8'h08, st(1'b0, 4'h0, 1'b1, 2'h3, 1'b1));
    repeat (10) @(posedge clk);
    rdc("inserted", 8'h08, st(1'b0, caps, 1'b1, 2'h0, 1'b1));
    rdc("flags", 8'h00, 32'h6);
    msweep(4'h6);
    m = caps;
    @(posedge clk);
    caps <= ~m;
    bv <= 1'b1;
    @(posedge clk);
    bv <= 1'b0;
    ls <= 1'b1;
    @(posedge clk);
    ls <= 1'b0;
    rdc("held", 8'h08, st(1'b0, m, 1'b1, 2'h0, 1'b1) | 32'h300);
    acc(1'b1, 8'h0c, 32'hc000_3c00);
    rdc("forced", 8'h08, 32'hd000_3c09);
    acc(1'b1, 8'h00, 32'hf);
    @(posedge clk);
    cs <= 1'b0;
    rdc("cardbus fall", 8'h00, 32'h0);
    @(posedge clk);
    cbc <= 1'b0;
    cs <= 1'b1;
    acc(1'b1, 8'h00, 32'h1);
    @(posedge clk);
    cs <= 1'b0;
    rdc("16-bit fall", 8'h00, 32'h1);
    chk("irq", 32'h1, {31'h0, irq});
    acc(1'b1, 8'h04, 32'h9);
    @(posedge clk);
    pme <= 1'b1;
    brst <= 1'b1;
    @(posedge clk);
    brst <= 1'b0;
    rdc("mask kept", 8'h04, 32'h9);
    @(posedge clk);
    pme <= 1'b0;
    brst <= 1'b1;
    @(posedge clk);
    brst <= 1'b0;
    rdc("mask clr", 8'h04, 32'h0);
    acc(1'b0, 8'h08, 32'h0);
    chk("sticky", 32'hc000_0000, d & 32'he000_3f00);
    tally_and_finish;
  end
endmodule
bind cardbus_socket_status_mask sock_mask_checker chk_u (.clk(clk), .rst(rst),
  .bus_reset_pin(bus_reset_pin), .pme_enable(pme_enable), .ctrl_5v_override(ctrl_5v_override),
  .req(req), .sock(sock), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
  .status_change_interrupt(status_change_interrupt));
